// File: phy_10base_codec_crs_far_end_fault_pattern_bench.sv
// Self-checking bench for the codec core: APB registers, 10/100 transmit, loopback receive, fiber fault pattern.
// Assumes phyc_consts.svh and the package are compiled first; the MAC model drives the nibble side.
`timescale 1ns/100ps
`include "phyc_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module phy_10base_codec_crs_far_end_fault_pattern_bench;
  localparam logic [7:0] A_CTRL = {1'b0, `PHYC_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {1'b0, `PHYC_IDX_STAT, 2'b00};
  localparam logic [7:0] A_MODE = {1'b0, `PHYC_IDX_MODE, 2'b00};
  localparam logic [7:0] A_NONE = 8'h08;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic        mii_tx_clk, mii_rx_clk, mii_txen, mii_rxdv, mii_crs;
  logic [3:0]  mii_txd, mii_rxd;
  logic        line_rx, line_tx, frame_on_line, repeater_strap_pin, speed_100, fiber_mode;
  logic        fx_signal_ok, fx_rx_clk, fx_rx_data, fx_tx_clk, fx_tx_data, media_enable, an_restart;
  logic        loop_on, sync_seen, crs_seen, ar_seen;
  int          error_cnt, num_checks, cyc, t0, hi_run, last_hi, k, ones;
  logic [3:0]  exp_q[$];

  phyc_core dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mii_tx_clk, .mii_rx_clk, .mii_txen, .mii_txd, .mii_rxd, .mii_rxdv, .mii_crs, .line_rx, .line_tx,
    .frame_on_line, .repeater_strap_pin, .speed_100, .fiber_mode, .fx_signal_ok, .fx_rx_clk, .fx_rx_data,
    .fx_tx_clk, .fx_tx_data, .media_enable, .an_restart);
  phyc_mac_model mac (.clk(clk), .tx_clk(mii_tx_clk), .txen(mii_txen), .txd(mii_txd));

  // The twisted pair idles low, so an unlooped line reads as idle.
  assign line_rx = loop_on ? line_tx : 1'b0;

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc >= 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  always @(posedge clk) begin
    if (mii_crs === 1'b1) crs_seen <= 1'b1;
    if (an_restart === 1'b1) ar_seen <= 1'b1;
    if (line_tx === 1'b1) hi_run <= hi_run + 1;
    else begin
      if (hi_run > 0) last_hi <= hi_run;
      hi_run <= 0;
    end
  end

  // Nibbles after the delimiter nibble are taken off the queue; any extra one is a fault.
  always @(posedge mii_rx_clk) begin
    if (mii_rxdv !== 1'b1) sync_seen = 1'b0;
    else if (sync_seen !== 1'b1) sync_seen = (mii_rxd === 4'hD);
    else if (exp_q.size() > 0) `CHK(mii_rxd, exp_q.pop_front())
    else `CHK(mii_rxdv, 1'b0)
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic media_wait();
    for (k = 0; k < 150 && media_enable !== 1'b1; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    `CHK((cyc - t0 - 3 >= 100) && (cyc - t0 - 3 <= 105), 1'b1)
    `CHK(ar_seen, 1'b1)
  endtask

  task automatic tx_crs(input logic exp, input int bound);
    @(posedge clk) crs_seen <= 1'b0;
    mac.send($urandom, 4);
    `CHK(mii_crs, exp)
    for (k = 0; k < bound && (mii_crs !== 1'b0 || frame_on_line !== 1'b0); k++) @(posedge clk);
    `CHK({mii_crs, frame_on_line}, 2'b00)
    `CHK(crs_seen, exp)
  endtask

  task automatic fx_pat();
    repeat (3) for (int b = 0; b < 85; b++) begin
      fx_rx_data <= (b < `PHYC_FAR_END_FAULT_PATTERN_ONES);
      repeat (4) @(posedge clk);
      fx_rx_clk <= 1'b1;
      repeat (4) @(posedge clk);
      fx_rx_clk <= 1'b0;
    end
    fx_rx_data <= ~fx_rx_data;
    repeat (10) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("Checks: %0d, errors: %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {clk, rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {repeater_strap_pin, speed_100, fiber_mode, fx_rx_clk, fx_rx_data, loop_on} = '0;
    {crs_seen, ar_seen, fx_signal_ok} = 3'b001;
    {error_cnt, num_checks, cyc, hi_run, last_hi} = '0;
    void'($urandom(32'h0BF004C0));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t0 = cyc;
    apb(1'b0, A_CTRL, 32'h0); `CHK(rd[15:0], `PHYC_CTRL_RST)
    apb(1'b0, A_MODE, 32'h0); `CHK(rd[15:0], `PHYC_MODE_RST)
    apb(1'b1, A_NONE, 32'hFFFFFFFF); `CHK(er, 1'b1)
    apb(1'b0, A_NONE, 32'h0); `CHK({er, rd}, 33'h100000000)
    media_wait();
    apb(1'b0, A_STAT, 32'h0); `CHK(rd[2], 1'b1)
    tx_crs(1'b1, 120);
    repeater_strap_pin <= 1'b1;
    repeat (10) @(posedge clk);
    tx_crs(1'b0, 120);
    repeater_strap_pin <= 1'b0;
    apb(1'b1, A_MODE, 32'h8000);
    tx_crs(1'b0, 120);
    apb(1'b1, A_CTRL, 32'h8000);
    apb(1'b1, A_CTRL, 32'h0);
    t0 = cyc;
    ar_seen <= 1'b0;
    apb(1'b0, A_MODE, 32'h0); `CHK(rd[15:0], `PHYC_MODE_RST)
    apb(1'b0, A_STAT, 32'h0); `CHK(rd[2], 1'b0)
    media_wait();
    tx_crs(1'b1, 120);
    loop_on <= 1'b1;
    repeat (2) begin
      r = $urandom;
      for (int i = 0; i < 3; i++) exp_q.push_back(r[4*i+:4]);
      mac.send({r[11:0], 4'hD, 16'h5555}, 8);
      repeat (80) @(posedge clk);
      `CHK(exp_q.size(), 0)
      `CHK((last_hi >= 15) && (last_hi <= 18), 1'b1)
      `CHK(line_tx, 1'b0)
    end
    loop_on <= 1'b0;
    speed_100 <= 1'b1;
    repeat (10) @(posedge clk);
    tx_crs(1'b1, 11);
    speed_100  <= 1'b0;
    fiber_mode <= 1'b1;
    repeat (10) @(posedge clk);
    fx_pat();
    apb(1'b0, A_STAT, 32'h0); `CHK(rd[4], 1'b1)
    apb(1'b0, A_STAT, 32'h0); `CHK(rd[4], 1'b0)
    fx_signal_ok <= 1'b0;
    // The pin synchroniser delays the start, so wait for the first one of the pattern before counting.
    do @(posedge fx_tx_clk); while (fx_tx_data !== 1'b1);
    ones = 0;
    do begin
      if (fx_tx_data === 1'b1) ones++;
      @(posedge fx_tx_clk);
    end while (fx_tx_data === 1'b1);
    `CHK(ones, `PHYC_FAR_END_FAULT_PATTERN_ONES)
    fiber_mode   <= 1'b0;
    fx_signal_ok <= 1'b1;
    repeat (10) @(posedge clk);
    fx_pat();
    apb(1'b0, A_STAT, 32'h0); `CHK(rd[4], 1'b0)
    report_and_stop();
  end
endmodule // phy_10base_codec_crs_far_end_fault_pattern_bench

// File: phyc_consts.svh
// Constants for the 10 Mbps codec, carrier sense and far-end-fault slice.
// Assumes a 50 MHz core clock; included by the package and the core.
`ifndef PHYC_CONSTS_SVH
`define PHYC_CONSTS_SVH
`define PHYC_CLK_MHZ    50
`define PHYC_CYC_UP(ns) ((((ns) * `PHYC_CLK_MHZ) + 999) / 1000)
`define PHYC_CYC_DN(ns) (((ns) * `PHYC_CLK_MHZ) / 1000)
`define PHYC_IDX_CTRL   5'h00
`define PHYC_IDX_STAT   5'h01
`define PHYC_IDX_MODE   5'h11
`define PHYC_BIT_SRST   15
`define PHYC_BIT_RF     4
`define PHYC_BIT_LINK   2
`define PHYC_BIT_RPT    15
`define PHYC_CTRL_RST   16'h0000
`define PHYC_MODE_RST   16'h0000
`define PHYC_MII10_NS   400
`define PHYC_MII100_NS  40
`define PHYC_BIT_NS     100
`define PHYC_HALF1_NS   40
`define PHYC_SOI_NS     300
`define PHYC_BITQ_NS    75
`define PHYC_RXIDLE_NS  160
`define PHYC_LINKDN_NS  2000
`define PHYC_FXCLK_NS   160
`define PHYC_FAR_END_FAULT_PATTERN_ONES  84
`define PHYC_FAR_END_FAULT_PATTERN_HITS  3
`endif

// File: phyc_core.sv
// 10 Mbps Manchester codec, carrier sense, reset handling and fiber fault pattern, APB registers.
// Assumes a 50 MHz clk; MII transmit inputs are launched by the MAC from the clock made here.
// Notes on behaviour
// - Serialize each nibble taken at 2.5MHz clock.
// - Manchester-encode, then add start-of-idle pulse.
// - Decode Manchester, drop trailing start-of-idle pulse.
// - Pack received bits into 4 bit nibbles.
// - Repeater when mode bit or strap set.
// - Repeater: carrier sense only on receive.
// - NIC: carrier sense on transmit and receive.
// - NIC mode by default.
// - Soft reset: control bit written one, then zero.
// - Any reset restores register reset values.
// - After reset drop link, restart negotiation.
// - Fault pattern: 84 ones, then one zero.
// - Three detected patterns set remote fault.
// - Failed incoming signal sends fault pattern.
// - Fault pattern only in fiber mode.
// - NIC carrier sense rises soon after enable.
// - Carrier sense falls soon after enable drops.
// - 100 Mbps frame ends soon after enable drops.
`timescale 1ns/100ps
`include "phyc_consts.svh"
module phyc_core (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        mii_tx_clk,
  output      logic        mii_rx_clk,
  input  wire logic        mii_txen,
  input  wire logic [3:0]  mii_txd,
  output      logic [3:0]  mii_rxd,
  output      logic        mii_rxdv,
  output      logic        mii_crs,
  input  wire logic        line_rx,
  output      logic        line_tx,
  output      logic        frame_on_line,
  input  wire logic        repeater_strap_pin,
  input  wire logic        speed_100,
  input  wire logic        fiber_mode,
  input  wire logic        fx_signal_ok,
  input  wire logic        fx_rx_clk,
  input  wire logic        fx_rx_data,
  output      logic        fx_tx_clk,
  output      logic        fx_tx_data,
  output      logic        media_enable,
  output      logic        an_restart
);
  localparam logic [3:0] MII10_T  = 4'(`PHYC_CYC_DN(`PHYC_MII10_NS / 2) - 1);
  localparam logic [3:0] MII100_T = 4'(`PHYC_CYC_DN(`PHYC_MII100_NS / 2) - 1);
  localparam logic [2:0] BIT_T    = 3'(`PHYC_CYC_DN(`PHYC_BIT_NS) - 1);
  localparam logic [2:0] HALF1    = 3'(`PHYC_CYC_DN(`PHYC_HALF1_NS));
  localparam logic [3:0] SOI_T    = 4'(`PHYC_CYC_UP(`PHYC_SOI_NS) - 1);
  localparam logic [4:0] BITQ     = 5'(`PHYC_CYC_UP(`PHYC_BITQ_NS));
  localparam logic [4:0] RXIDLE   = 5'(`PHYC_CYC_DN(`PHYC_RXIDLE_NS));
  localparam logic [6:0] LK_T     = 7'(`PHYC_CYC_DN(`PHYC_LINKDN_NS) - 1);
  localparam logic [1:0] FX_T     = 2'(`PHYC_CYC_UP(`PHYC_FXCLK_NS / 2) - 1);
  localparam logic [6:0] ONES     = 7'(`PHYC_FAR_END_FAULT_PATTERN_ONES);
  localparam logic [1:0] HITS_T   = 2'(`PHYC_FAR_END_FAULT_PATTERN_HITS - 1);

  phyc_pkg::phyc_st_type   q;
  phyc_pkg::phyc_st_type   d;
  phyc_pkg::phyc_pins_type pin_raw;
  phyc_pkg::phyc_pins_type p;
  logic                    rpt;
  logic                    srst;
  logic                    far_end_fault_pattern_hit;
  logic                    take;
  logic                    tick;
  logic                    rise;
  logic                    fall;
  logic                    fx_rise;
  logic                    fx_tick;
  logic                    acc;
  logic                    bit_now;

  function automatic logic at_idx(input logic [7:0] a, input logic [4:0] idx);
    at_idx = (a == {1'b0, idx, 2'b00});
  endfunction

  function automatic logic [31:0] rd_word(input phyc_pkg::phyc_st_type s, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    if (at_idx(a, `PHYC_IDX_CTRL)) begin
      rd_word[15:0] = s.ctrl;
    end else if (at_idx(a, `PHYC_IDX_MODE)) begin
      rd_word[15:0] = s.mode;
    end else if (at_idx(a, `PHYC_IDX_STAT)) begin
      rd_word[`PHYC_BIT_RF]   = s.rf;
      rd_word[`PHYC_BIT_LINK] = s.media_en;
    end
  endfunction

  assign pin_raw = '{line_rx: line_rx, rpt_strap: repeater_strap_pin, speed100: speed_100,
                     fiber: fiber_mode, fx_sig_ok: fx_signal_ok, fx_clk: fx_rx_clk,
                     fx_data: fx_rx_data};

  phyc_sync u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (pin_raw),
    .dout (p)
  );

  assign rpt = q.mode[`PHYC_BIT_RPT] | p.rpt_strap;

  always_comb begin
    d            = q;
    d.an_restart = 1'b0;
    d.pready     = 1'b0;
    srst         = 1'b0;
    far_end_fault_pattern_hit     = 1'b0;
    take         = 1'b0;

    // MII clock: both directions share one divided clock.
    tick      = (q.mii_cnt == (p.speed100 ? MII100_T : MII10_T));
    d.mii_cnt = tick ? 4'h0 : q.mii_cnt + 4'h1;
    if (tick) begin
      d.mii_clk = ~q.mii_clk;
    end
    rise = tick & ~q.mii_clk;
    fall = tick & q.mii_clk;
    if (rise) begin
      d.txen_s = mii_txen;
    end

    // Transmit: one nibble lasts exactly four bit times, so reloads meet the next rising edge.
    bit_now = q.sh[q.bidx];
    unique case (q.tx_st)
      phyc_pkg::PHYC_TX_IDLE: begin
        d.line_tx = 1'b0;
        if (rise && mii_txen && !p.speed100) begin
          d.sh    = mii_txd;
          d.tx_st = phyc_pkg::PHYC_TX_DATA;
          d.bcyc  = 3'h0;
          d.bidx  = 2'h0;
        end
      end
      phyc_pkg::PHYC_TX_DATA: begin
        d.line_tx = (q.bcyc < HALF1) ? ~bit_now : bit_now;
        d.bcyc    = (q.bcyc == BIT_T) ? 3'h0 : q.bcyc + 3'h1;
        if (q.bcyc == BIT_T) begin
          d.bidx = q.bidx + 2'h1;
          if (q.bidx == 2'h3) begin
            if (rise && mii_txen) begin
              d.sh = mii_txd;
            end else begin
              d.tx_st   = phyc_pkg::PHYC_TX_SOI;
              d.soi_cnt = 4'h0;
            end
          end
        end
      end
      phyc_pkg::PHYC_TX_SOI: begin
        // Held high, then released to idle, giving the idle pulse after the last bit.
        d.line_tx = 1'b1;
        d.soi_cnt = q.soi_cnt + 4'h1;
        if (q.soi_cnt == SOI_T) begin
          d.tx_st = phyc_pkg::PHYC_TX_IDLE;
        end
      end
      default: begin
        d.tx_st = phyc_pkg::PHYC_TX_IDLE;
      end
    endcase
    d.frame = p.speed100 ? q.txen_s : (q.tx_st != phyc_pkg::PHYC_TX_IDLE);

    // Receive: a transition counts as a mid-bit one only after three quarters of a bit time.
    d.rx_prev = p.line_rx;
    if (!p.speed100 && (p.line_rx != q.rx_prev) && (q.carrier ? (q.since >= BITQ) : p.line_rx)) begin
      take      = 1'b1;
      d.carrier = 1'b1;
      d.since   = 5'h00;
    end else if (q.since != 5'h1F) begin
      d.since = q.since + 5'h01;
    end
    // The idle pulse has no mid-bit edge, so it times out here and a partial nibble is dropped.
    if (!take && q.carrier && (q.since >= RXIDLE)) begin
      d.carrier = 1'b0;
      d.rn      = 2'h0;
    end
    if (fall) begin
      if (q.hold.en) begin
        d.rxd     = q.hold.d;
        d.rxdv    = 1'b1;
        d.hold.en = 1'b0;
      end else if (!q.carrier) begin
        d.rxdv = 1'b0;
      end
    end
    if (take) begin
      d.rsh = {p.line_rx, q.rsh[3:1]};
      d.rn  = q.rn + 2'h1;
      if (q.rn == 2'h3) begin
        d.hold = '{en: 1'b1, d: {p.line_rx, q.rsh[3:1]}};
      end
    end

    d.crs = q.carrier | (~rpt & q.txen_s);

    // APB: setup cycle latches the answer, access cycle commits the write or read effect.
    if (psel && !penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = ~(at_idx(paddr, `PHYC_IDX_CTRL) | at_idx(paddr, `PHYC_IDX_STAT) |
                    at_idx(paddr, `PHYC_IDX_MODE));
      d.prdata  = rd_word(q, paddr);
    end
    acc = psel & penable & q.pready;
    if (acc && pwrite && at_idx(paddr, `PHYC_IDX_CTRL)) begin
      d.ctrl = pwdata[15:0];
      srst   = q.ctrl[`PHYC_BIT_SRST] & ~pwdata[`PHYC_BIT_SRST];
    end
    if (acc && pwrite && at_idx(paddr, `PHYC_IDX_MODE)) begin
      d.mode = pwdata[15:0];
    end
    // Only a fault that the read actually returned is cleared.
    if (acc && !pwrite && at_idx(paddr, `PHYC_IDX_STAT) && q.prdata[`PHYC_BIT_RF]) begin
      d.rf   = 1'b0;
      d.hits = 2'h0;
    end

    // Fiber receive: sample data on the rising edge of the recovered link clock.
    d.fxc_prev = p.fx_clk;
    fx_rise    = p.fx_clk & ~q.fxc_prev;
    if (!p.fiber) begin
      d.ones = 7'h00;
    end else if (fx_rise) begin
      if (p.fx_data) begin
        d.ones = (q.ones == 7'h7F) ? q.ones : q.ones + 7'h01;
      end else begin
        far_end_fault_pattern_hit = (q.ones == ONES);
        d.ones   = 7'h00;
      end
    end
    if (far_end_fault_pattern_hit) begin
      if (q.hits != 2'h3) begin
        d.hits = q.hits + 2'h1;
      end
      if (q.hits >= HITS_T) begin
        d.rf = 1'b1;
      end
    end

    // Fiber transmit: this end makes its own link clock and changes data on its falling edge.
    fx_tick  = (q.fx_cnt == FX_T);
    d.fx_cnt = fx_tick ? 2'h0 : q.fx_cnt + 2'h1;
    if (fx_tick) begin
      d.fx_clk = ~q.fx_clk;
    end
    if (fx_tick && q.fx_clk) begin
      if (p.fiber && !p.fx_sig_ok) begin
        d.fx_tx   = (q.fx_bits != ONES);
        d.fx_bits = (q.fx_bits == ONES) ? 7'h00 : q.fx_bits + 7'h01;
      end else begin
        d.fx_tx   = 1'b0;
        d.fx_bits = 7'h00;
      end
    end

    // Link stays down for a while after any reset, then negotiation restarts.
    if (!q.media_en) begin
      if (q.lk_cnt == LK_T) begin
        d.media_en   = 1'b1;
        d.an_restart = 1'b1;
      end else begin
        d.lk_cnt = q.lk_cnt + 7'h01;
      end
    end

    if (srst) begin
      d.ctrl     = `PHYC_CTRL_RST;
      d.mode     = `PHYC_MODE_RST;
      d.rf       = 1'b0;
      d.hits     = 2'h0;
      d.ones     = 7'h00;
      d.media_en = 1'b0;
      d.lk_cnt   = 7'h00;
    end
  end

  // The hardware reset pin is rstn; its length is the host's business.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q      <= '0;
      q.ctrl <= `PHYC_CTRL_RST;
      q.mode <= `PHYC_MODE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign mii_tx_clk    = q.mii_clk;
  assign mii_rx_clk    = q.mii_clk;
  assign mii_rxd       = q.rxd;
  assign mii_rxdv      = q.rxdv;
  assign mii_crs       = q.crs;
  assign line_tx       = q.line_tx;
  assign frame_on_line = q.frame;
  assign fx_tx_clk     = q.fx_clk;
  assign fx_tx_data    = q.fx_tx;
  assign media_enable  = q.media_en;
  assign an_restart    = q.an_restart;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_tx_end;
    (q.tx_st == phyc_pkg::PHYC_TX_DATA) ##1 (q.tx_st == phyc_pkg::PHYC_TX_SOI);
  endsequence

  sequence s_third_hit;
    far_end_fault_pattern_hit && (q.hits >= HITS_T) && !srst;
  endsequence

  a_soi_pulse_high:
    assert property (s_tx_end |=> line_tx [*8]) else $error("idle pulse shorter than expected");
  a_crs_nic_tx:
    assert property ((q.txen_s && !rpt) |=> mii_crs) else $error("carrier sense missing on transmit");
  a_crs_rpt_rx:
    assert property (rpt |=> (mii_crs == $past(q.carrier))) else $error("repeater carrier sense wrong");
  a_crs_drop_idle:
    assert property ((!q.txen_s && !q.carrier) |=> !mii_crs) else $error("carrier sense did not drop");
  a_rf_three_hits:
    assert property (s_third_hit |=> q.rf) else $error("remote fault not set after three patterns");
  a_far_end_fault_pattern_fiber_only:
    assert property (!p.fiber [*8] |=> !fx_tx_data) else $error("fault pattern outside fiber mode");
  a_soft_rst_vals:
    assert property (srst |=> (q.ctrl == `PHYC_CTRL_RST && q.mode == `PHYC_MODE_RST && !q.rf))
      else $error("soft reset did not restore registers");
  a_link_drop_rst:
    assert property (srst |=> !media_enable [*8]) else $error("link not dropped after soft reset");
  a_frame_end_100:
    assert property ((p.speed100 && !q.txen_s) |=> !frame_on_line) else $error("frame did not end");
endmodule // phyc_core

// File: phyc_mac_model.sv
// Behavioural MAC on the MII transmit side of the codec core.
// Assumes mii_tx_clk comes from the core and is sampled here on the core clock.
`timescale 1ns/100ps
module phyc_mac_model (
  input  wire logic       clk,
  input  wire logic       tx_clk,
  output      logic       txen,
  output      logic [3:0] txd
);
  logic prev_q;

  initial begin
    txen   = 1'b0;
    txd    = 4'h0;
    prev_q = 1'b0;
  end

  always @(posedge clk) begin
    prev_q <= tx_clk;
  end

  // Launch just after the edge where tx_clk rose, so the core samples a full period later.
  task automatic launch();
    do @(posedge clk); while (!(tx_clk === 1'b1 && prev_q === 1'b0));
  endtask

  // One nibble per transmit clock, lowest nibble first; released data shows its inverse.
  task automatic send(input logic [31:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      launch();
      txen <= 1'b1;
      txd  <= d[4*i+:4];
    end
    launch();
    txen <= 1'b0;
    txd  <= ~txd;
  endtask
endmodule // phyc_mac_model

// File: phyc_pkg.sv
// Types shared by the codec core and its pin synchroniser.
// Assumes phyc_consts.svh is on the include path.
`include "phyc_consts.svh"
package phyc_pkg;
  typedef enum logic [1:0] {
    PHYC_TX_IDLE = 2'b00,
    PHYC_TX_DATA = 2'b01,
    PHYC_TX_SOI  = 2'b10
  } phyc_tx_type;

  typedef struct packed {
    logic line_rx;
    logic rpt_strap;
    logic speed100;
    logic fiber;
    logic fx_sig_ok;
    logic fx_clk;
    logic fx_data;
  } phyc_pins_type;

  typedef struct packed {
    phyc_pins_type s1;
    phyc_pins_type s2;
    phyc_pins_type s3;
    phyc_pins_type q;
  } phyc_sync_type;

  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } phyc_nib_type;

  typedef struct packed {
    logic [3:0]  mii_cnt;
    logic        mii_clk;
    logic        txen_s;
    phyc_tx_type tx_st;
    logic [3:0]  sh;
    logic [2:0]  bcyc;
    logic [1:0]  bidx;
    logic [3:0]  soi_cnt;
    logic        line_tx;
    logic        frame;
    logic        rx_prev;
    logic        carrier;
    logic [4:0]  since;
    logic [3:0]  rsh;
    logic [1:0]  rn;
    phyc_nib_type hold;
    logic [3:0]  rxd;
    logic        rxdv;
    logic        crs;
    logic [15:0] ctrl;
    logic [15:0] mode;
    logic        rf;
    logic [1:0]  hits;
    logic [6:0]  ones;
    logic        fxc_prev;
    logic [1:0]  fx_cnt;
    logic        fx_clk;
    logic [6:0]  fx_bits;
    logic        fx_tx;
    logic [6:0]  lk_cnt;
    logic        media_en;
    logic        an_restart;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } phyc_st_type;
endpackage

// File: phyc_sync.sv
// Three-stage synchroniser for all pins that arrive from outside the clock domain.
// Assumes pins are static for at least three clocks around each change.
`timescale 1ns/100ps
module phyc_sync (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire phyc_pkg::phyc_pins_type din,
  output      phyc_pkg::phyc_pins_type dout
);
  phyc_pkg::phyc_sync_type q;
  phyc_pkg::phyc_sync_type d;

  // The first stage feeds only the second; a bit moves once stages two and three agree.
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.q  = (q.s2 & q.s3) | (q.q & (q.s2 ^ q.s3));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.q;
endmodule // phyc_sync
